//--- core/enc_ch1_pkg.sv
// package: constants for the channel-one incremental encoder front end
// assumes a 125 MHz mclk and a two-track digital encoder on pins
package enc_ch1_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BASE_CYCLE_US = 125;
  localparam int unsigned BASE_CYCLE_CLKS = CLK_HZ / 1_000_000 * BASE_CYCLE_US;
  localparam int unsigned MS_CLKS = CLK_HZ / 1_000;
  localparam logic [3:0] CHANNEL_DIGITAL = 4'h3;
  localparam logic [2:0] ABS_OFF = 3'h0;
  localparam logic [2:0] ABS_SERIAL = 3'h1;
  localparam logic [2:0] ABS_LAST = 3'h4;
  localparam logic [2:0] FMT_QUAD_FWD = 3'h0;
  localparam logic [2:0] FMT_QUAD_REV = 3'h1;
  localparam logic [2:0] FMT_STEP_FALL = 3'h2;
  localparam logic [2:0] FMT_STEP_RISE = 3'h3;
  localparam logic [7:0] SAMPLE_INTERVAL_RESET = 8'h01;
  localparam int unsigned POS_W = 32;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned TIMEOUT_W = 16;
endpackage

//--- core/enc_tick_gen.sv
// tick generator: one pulse every n base cycles of 125 us
// assumes mclk at the rate held in the package
`timescale 1ns/1ps
module enc_tick_gen (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] interval,
  output logic sample_tick,
  output logic ms_tick
);
  logic [15:0] base_q;
  logic [7:0] mult_q;
  logic [16:0] ms_q;
  logic base_end;
  logic [7:0] n_eff;

  assign base_end = (base_q == 16'(enc_ch1_pkg::BASE_CYCLE_CLKS - 1));
  // interval of zero is treated as one so sampling never stops
  assign n_eff = (interval == 8'h00) ? 8'h01 : interval;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      base_q <= 16'h0000;
    end else if (clk_en) begin
      base_q <= base_end ? 16'h0000 : base_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mult_q <= 8'h00;
      sample_tick <= 1'b0;
    end else if (clk_en) begin
      sample_tick <= 1'b0;
      if (base_end) begin
        if (mult_q >= n_eff - 8'h01) begin
          mult_q <= 8'h00;
          sample_tick <= 1'b1;
        end else begin
          mult_q <= mult_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ms_q <= 17'h0_0000;
      ms_tick <= 1'b0;
    end else if (clk_en) begin
      ms_tick <= (ms_q == 17'(enc_ch1_pkg::MS_CLKS - 1));
      ms_q <= (ms_q == 17'(enc_ch1_pkg::MS_CLKS - 1)) ? 17'h0_0000 : ms_q + 17'h0_0001;
    end
  end
endmodule

//--- core/incremental_encoder_channel.sv
// incremental encoder channel one: decode, position count, speed, index
// assumes encoder tracks arrive asynchronously on pins; settings are static ports
//
// Notes on behaviour
// - channel select 3 enables digital decode
// - absolute select 0 off, 1-4 interfaces
// - absolute position loaded once at init
// - format 0 quadrature x4, 1 reversed
// - format 2 falling A, B high positive
// - format 3 rising A, B high negative
// - no count for n ms zeroes speed
// - index evaluated only while homing active or index test mode set
// - index test mode 1 evaluates index
// - test mode shows index on observers
// - linear run rotary: lines per revolution
// - evaluate every n times 125 us
// - sample interval count defaults to one
`timescale 1ns/1ps
module incremental_encoder_channel (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic track_a,
  input wire logic track_b,
  input wire logic index_pulse,
  input wire logic [3:0] encoder_channel_select,
  input wire logic [2:0] absolute_interface_select,
  input wire logic [2:0] pulse_signal_format,
  input wire logic [15:0] inactivity_timeout_ms,
  input wire logic index_test_mode,
  input wire logic [31:0] lines_per_revolution,
  input wire logic [7:0] sample_interval_count,
  input wire logic homing_active,
  input wire logic abs_valid,
  input wire logic [31:0] abs_position,
  output logic abs_request,
  output logic init_done,
  output logic [31:0] position,
  output logic [31:0] rev_count,
  output logic [15:0] speed,
  output logic index_seen,
  output logic observe_1014,
  output logic observe_1016
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q <= 3'h0;
    end else if (clk_en) begin
      sync1_q <= {index_pulse, track_b, track_a};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic a_s, b_s, a_p, b_p, z_s, z_p;
  assign a_s = sync2_q[0];
  assign b_s = sync2_q[1];
  assign z_s = sync2_q[2];
  assign a_p = prev_q[0];
  assign b_p = prev_q[1];
  assign z_p = prev_q[2];

  // ---------------------------------------------------------------
  // sample timing
  // ---------------------------------------------------------------
  logic [7:0] interval_q;
  logic sample_tick;
  logic ms_tick;

  // setting is captured after reset; reset value is one base cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      interval_q <= enc_ch1_pkg::SAMPLE_INTERVAL_RESET;
    end else if (clk_en) begin
      interval_q <= sample_interval_count;
    end
  end

  enc_tick_gen u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .interval(interval_q),
    .sample_tick(sample_tick),
    .ms_tick(ms_tick)
  );

  // ---------------------------------------------------------------
  // edge decode
  // ---------------------------------------------------------------
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    // returns {valid, up}; gray order 00-01-11-10 counts up
    logic [3:0] t;
    t = {prv, cur};
    case (t)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b11;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b10;
      default: quad_step = 2'b00;
    endcase
  endfunction

  logic enabled;
  logic step_valid;
  logic step_up;
  logic [1:0] q;

  assign enabled = (encoder_channel_select == enc_ch1_pkg::CHANNEL_DIGITAL) && init_done;
  assign q = quad_step({b_p, a_p}, {b_s, a_s});

  always_comb begin
    step_valid = 1'b0;
    step_up = 1'b0;
    case (pulse_signal_format)
      enc_ch1_pkg::FMT_QUAD_FWD: begin
        step_valid = q[1];
        step_up = q[0];
      end
      enc_ch1_pkg::FMT_QUAD_REV: begin
        step_valid = q[1];
        step_up = ~q[0];
      end
      enc_ch1_pkg::FMT_STEP_FALL: begin
        step_valid = a_p & ~a_s;
        step_up = b_s;
      end
      enc_ch1_pkg::FMT_STEP_RISE: begin
        step_valid = ~a_p & a_s;
        step_up = ~b_s;
      end
      default: begin
        step_valid = 1'b0; // format 4 and up reserved
        step_up = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // absolute initialisation
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    INIT_START = 3'b001,
    INIT_FETCH = 3'b010,
    INIT_RUN = 3'b100
  } init_state_e;
  init_state_e init_q;
  logic abs_sel;
  assign abs_sel = (absolute_interface_select != enc_ch1_pkg::ABS_OFF) &&
                   (absolute_interface_select <= enc_ch1_pkg::ABS_LAST);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      init_q <= INIT_START;
      abs_request <= 1'b0;
      init_done <= 1'b0;
    end else if (clk_en) begin
      case (init_q)
        INIT_START: begin
          if (abs_sel) begin
            init_q <= INIT_FETCH;
            abs_request <= 1'b1;
          end else begin
            init_q <= INIT_RUN;
            init_done <= 1'b1;
          end
        end
        INIT_FETCH: begin
          if (abs_valid) begin
            init_q <= INIT_RUN; // single read, never repeated
            abs_request <= 1'b0;
            init_done <= 1'b1;
          end
        end
        default: begin
          init_q <= INIT_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // position, revolution count
  // ---------------------------------------------------------------
  logic [31:0] line_q;
  logic [31:0] max_line;
  assign max_line = (lines_per_revolution == 32'h0000_0000) ? 32'h0000_0000 :
                    lines_per_revolution - 32'h0000_0001;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      position <= 32'h0000_0000;
      line_q <= 32'h0000_0000;
      rev_count <= 32'h0000_0000;
    end else if (clk_en) begin
      if (init_q == INIT_FETCH && abs_valid) begin
        position <= abs_position;
      end else if (enabled && step_valid) begin
        position <= step_up ? position + 32'h0000_0001 : position - 32'h0000_0001;
        // one revolution per line count, i.e. one pole pitch on linear drives
        if (step_up) begin
          if (line_q >= max_line) begin
            line_q <= 32'h0000_0000;
            rev_count <= rev_count + 32'h0000_0001;
          end else begin
            line_q <= line_q + 32'h0000_0001;
          end
        end else begin
          if (line_q == 32'h0000_0000) begin
            line_q <= max_line;
            rev_count <= rev_count - 32'h0000_0001;
          end else begin
            line_q <= line_q - 32'h0000_0001;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // speed per sample interval, inactivity zeroing
  // ---------------------------------------------------------------
  logic [31:0] last_pos_q;
  logic [15:0] idle_ms_q;
  logic idle;

  assign idle = (inactivity_timeout_ms != 16'h0000) && (idle_ms_q >= inactivity_timeout_ms);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_ms_q <= 16'h0000;
    end else if (clk_en) begin
      if (enabled && step_valid) begin
        idle_ms_q <= 16'h0000;
      end else if (ms_tick && idle_ms_q != 16'hffff) begin
        idle_ms_q <= idle_ms_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_pos_q <= 32'h0000_0000;
      speed <= 16'h0000;
    end else if (clk_en) begin
      if (idle) begin
        speed <= 16'h0000;
      end else if (sample_tick) begin
        speed <= 16'(position - last_pos_q);
      end
      if (sample_tick) begin
        last_pos_q <= position;
      end
    end
  end

  // ---------------------------------------------------------------
  // index pulse
  // ---------------------------------------------------------------
  logic index_rise;
  assign index_rise = z_s & ~z_p;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      index_seen <= 1'b0;
      observe_1014 <= 1'b0;
      observe_1016 <= 1'b0;
    end else if (clk_en) begin
      if (homing_active || index_test_mode) begin
        if (index_rise) begin
          index_seen <= 1'b1;
        end
      end else begin
        index_seen <= 1'b0;
      end
      observe_1014 <= index_test_mode & z_s;
      observe_1016 <= index_test_mode & index_rise;
    end
  end
endmodule

//--- verification/enc_ch1_checker.sv
// checker: port-level properties of encoder channel one
// assumes it is bound onto incremental_encoder_channel
`timescale 1ns/1ps
module enc_ch1_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] encoder_channel_select,
  input wire logic [2:0] absolute_interface_select,
  input wire logic [2:0] pulse_signal_format,
  input wire logic index_test_mode,
  input wire logic homing_active,
  input wire logic abs_valid,
  input wire logic [31:0] abs_position,
  input wire logic abs_request,
  input wire logic init_done,
  input wire logic [31:0] position,
  input wire logic index_seen,
  input wire logic observe_1014,
  input wire logic observe_1016
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_abs_load;
    abs_request && abs_valid && clk_en |=> init_done && !abs_request && position == $past(abs_position);
  endproperty
  a_abs_load: assert property (p_abs_load) else $error("absolute load wrong");
  property p_abs_once;
    init_done |=> init_done;
  endproperty
  a_abs_once: assert property (p_abs_once) else $error("init done dropped");
  property p_abs_sel;
    $rose(abs_request) |-> absolute_interface_select inside {[3'h1:3'h4]};
  endproperty
  a_abs_sel: assert property (p_abs_sel) else $error("fetch with bad select");
  property p_abs_off;
    absolute_interface_select == enc_ch1_pkg::ABS_OFF |-> !abs_request;
  endproperty
  a_abs_off: assert property (p_abs_off) else $error("fetch while off");
  property p_sel_hold;
    init_done && encoder_channel_select != enc_ch1_pkg::CHANNEL_DIGITAL |=> $stable(position);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("count on other channel");
  property p_fmt_res;
    init_done && pulse_signal_format > enc_ch1_pkg::FMT_STEP_RISE |=> $stable(position);
  endproperty
  a_fmt_res: assert property (p_fmt_res) else $error("count in reserved format");
  property p_obs_off;
    !index_test_mode && clk_en |=> !observe_1014 && !observe_1016;
  endproperty
  a_obs_off: assert property (p_obs_off) else $error("observer without test mode");
  property p_idx_off;
    !homing_active && !index_test_mode && clk_en |=> !index_seen;
  endproperty
  a_idx_off: assert property (p_idx_off) else $error("index without enable");
  property p_step;
    init_done && $past(init_done) |-> (position - $past(position)) inside {32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF};
  endproperty
  a_step: assert property (p_step) else $error("position jumped");
  c_abs: cover property (abs_request && abs_valid);
  c_obs: cover property (observe_1016);
  c_idx: cover property (index_seen && homing_active);
endmodule
bind incremental_encoder_channel enc_ch1_checker chk_u (.mclk, .rstn, .clk_en, .encoder_channel_select,
  .absolute_interface_select, .pulse_signal_format, .index_test_mode, .homing_active, .abs_valid,
  .abs_position, .abs_request, .init_done, .position, .index_seen, .observe_1014, .observe_1016);

//--- verification/enc_model.sv
// encoder model: two tracks, index and a one-shot absolute answer
// assumes mclk of the block; tracks move only through the tasks
`timescale 1ns/1ps
module enc_model #(
  parameter int DLY = 20,
  parameter logic [31:0] ABS_VAL = 32'h0000_0000
) (
  input wire logic mclk,
  input wire logic abs_request,
  output logic abs_valid,
  output logic [31:0] abs_position,
  output logic track_a,
  output logic track_b,
  output logic index_pulse
);
  int cnt = 0;
  initial begin
    abs_valid = 1'b0;
    abs_position = ~ABS_VAL;
    track_a = 1'b0;
    track_b = 1'b0;
    index_pulse = 1'b0;
  end
  // answer late, hold until request drops; show a wrong pattern otherwise
  always @(posedge mclk) begin
    cnt <= abs_request ? cnt + 1 : 0;
    abs_valid <= abs_request && cnt >= DLY;
    abs_position <= (abs_request && cnt >= DLY) ? ABS_VAL : ~ABS_VAL;
  end
  task automatic put(input logic a, input logic b);
    @(posedge mclk);
    track_a <= a;
    track_b <= b;
    repeat (6) @(posedge mclk);
  endtask
  task automatic idx(input logic v);
    @(posedge mclk);
    index_pulse <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule

//--- verification/incremental_encoder_channel_tb.sv
// testbench: decode formats, gating, index and absolute start
// assumes enc_model on the pins and the bound checker
`timescale 1ns/1ps
module incremental_encoder_channel_tb;
  localparam logic [31:0] ABS_V = 32'h0000_0123;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] encoder_channel_select = 4'h3;
  logic [2:0] absolute_interface_select = 3'h0;
  logic [2:0] pulse_signal_format = 3'h0;
  logic index_test_mode = 1'b0;
  logic homing_active = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] inactivity_timeout_ms = 16'h0000;
  logic [31:0] lines_per_revolution = 32'h0000_0010;
  logic [7:0] sample_interval_count = 8'h01;
  logic [31:0] rev_count;
  logic [15:0] speed;
  int pulse_cnt = 0;
  // commutation finding lies outside this block; a motor bench must enable it
  logic track_a, track_b, index_pulse, abs_valid, abs_request, init_done;
  logic index_seen, observe_1014, observe_1016;
  logic [31:0] abs_position, position;
  int err_total = 0;
  int comparisons = 0;
  always #4 mclk = ~mclk;
  enc_model #(.DLY(20), .ABS_VAL(ABS_V)) model_u (.mclk, .abs_request, .abs_valid, .abs_position,
    .track_a, .track_b, .index_pulse);
  incremental_encoder_channel dut_u (.mclk, .rstn, .clk_en, .track_a, .track_b, .index_pulse,
    .encoder_channel_select, .absolute_interface_select, .pulse_signal_format,
    .inactivity_timeout_ms, .index_test_mode, .lines_per_revolution,
    .sample_interval_count, .homing_active, .abs_valid, .abs_position, .abs_request,
    .init_done, .position, .rev_count, .speed, .index_seen, .observe_1014, .observe_1016);
  // counts the one-cycle observer pulses, sampled while they stand
  always @(posedge mclk) begin
    if (observe_1016 === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst_to(input logic [2:0] a);
    @(posedge mclk);
    rstn <= 1'b0;
    absolute_interface_select <= a;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 200 && init_done !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
    chk({31'h0, init_done}, 32'h0000_0001);
    chk({31'h0, abs_request}, 32'h0000_0000);
    chk(position, (a == enc_ch1_pkg::ABS_OFF || a > enc_ch1_pkg::ABS_LAST) ? 32'h0000_0000 : ABS_V);
  endtask
  task automatic frz();
    logic [31:0] p;
    p = position;
    pulse_signal_format <= enc_ch1_pkg::FMT_QUAD_FWD;
    clk_en <= 1'b0;
    model_u.put(1'b1, 1'b0);
    chk(position, p);
    clk_en <= 1'b1;
    model_u.put(1'b1, 1'b0);
    chk(position, p + 32'h0000_0001);
    model_u.put(1'b0, 1'b0);
    chk(position, p);
  endtask
  // tick timing runs from reset release, so both moves fall inside known intervals
  task automatic spd();
    quad(enc_ch1_pkg::FMT_QUAD_FWD, 1'b0, 32'h0000_0004);
    chk(rev_count, 32'h0000_0001);
    repeat (enc_ch1_pkg::BASE_CYCLE_CLKS) @(posedge mclk);
    quad(enc_ch1_pkg::FMT_QUAD_FWD, 1'b0, 32'h0000_0004);
    chk(rev_count, 32'h0000_0002);
    repeat (enc_ch1_pkg::BASE_CYCLE_CLKS) @(posedge mclk);
    chk({16'h0000, speed}, 32'h0000_0004);
  endtask
  task automatic quad(input logic [2:0] f, input logic rev, input logic [31:0] d);
    logic [31:0] p;
    p = position;
    pulse_signal_format <= f;
    if (rev) begin
      model_u.put(1'b0, 1'b1);
      model_u.put(1'b1, 1'b1);
      model_u.put(1'b1, 1'b0);
    end else begin
      model_u.put(1'b1, 1'b0);
      model_u.put(1'b1, 1'b1);
      model_u.put(1'b0, 1'b1);
    end
    model_u.put(1'b0, 1'b0);
    chk(position, p + d);
  endtask
  task automatic step(input logic [2:0] f, input logic [31:0] s);
    logic [31:0] p;
    p = position;
    pulse_signal_format <= f;
    model_u.put(1'b0, 1'b1);
    model_u.put(1'b1, 1'b1);
    model_u.put(1'b0, 1'b1);
    chk(position, p + s);
    model_u.put(1'b0, 1'b0);
    model_u.put(1'b1, 1'b0);
    model_u.put(1'b0, 1'b0);
    chk(position, p);
  endtask
  task automatic ix(input logic tm, input logic hm, input logic [31:0] e);
    int n;
    n = pulse_cnt;
    index_test_mode <= tm;
    homing_active <= hm;
    model_u.idx(1'b1);
    chk({31'h0, observe_1014}, {31'h0, tm});
    chk(32'(pulse_cnt - n), {31'h0, tm});
    chk({31'h0, index_seen}, e);
    model_u.idx(1'b0);
  endtask
  task final_report;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_to(enc_ch1_pkg::ABS_OFF);
    quad(enc_ch1_pkg::FMT_QUAD_FWD, 1'b0, 32'h0000_0004);
    quad(enc_ch1_pkg::FMT_QUAD_FWD, 1'b1, 32'hFFFF_FFFC);
    quad(enc_ch1_pkg::FMT_QUAD_REV, 1'b0, 32'hFFFF_FFFC);
    quad(enc_ch1_pkg::FMT_QUAD_REV, 1'b1, 32'h0000_0004);
    quad(3'h4, 1'b0, 32'h0000_0000);
    encoder_channel_select <= 4'h0;
    quad(enc_ch1_pkg::FMT_QUAD_FWD, 1'b0, 32'h0000_0000);
    encoder_channel_select <= enc_ch1_pkg::CHANNEL_DIGITAL;
    step(enc_ch1_pkg::FMT_STEP_FALL, 32'h0000_0001);
    step(enc_ch1_pkg::FMT_STEP_RISE, 32'hFFFF_FFFF);
    frz();
    ix(1'b0, 1'b0, 32'h0000_0000);
    ix(1'b1, 1'b0, 32'h0000_0001);
    ix(1'b0, 1'b1, 32'h0000_0001);
    homing_active <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, index_seen}, 32'h0000_0000);
    rst_to(3'h5);
    rst_to(enc_ch1_pkg::ABS_LAST);
    lines_per_revolution <= 32'h0000_0004;
    rst_to(enc_ch1_pkg::ABS_SERIAL);
    spd();
    final_report;
  end
  initial begin
    #500_000;
    err_total++;
    final_report;
  end
endmodule
